// file: rtl/fsi_pkg.sv
// Package with register map, field positions and timing constants of the service intake block.
package fsi_pkg;
  // Register byte offsets on the APB side.
  localparam logic [7:0] OFS_BUF_RELEASE = 8'h14;
  localparam logic [7:0] OFS_AUX_SEL     = 8'h2A;
  localparam logic [7:0] OFS_SSA_PTR     = 8'h40;
  localparam logic [7:0] OFS_STATION     = 8'h44;
  localparam logic [7:0] OFS_LOCK        = 8'h48;
  localparam logic [7:0] OFS_SSA_LEN     = 8'h4C;
  localparam logic [7:0] OFS_STATUS      = 8'h50;
  localparam logic [7:0] OFS_PRM_LEN     = 8'h54;
  localparam logic [7:0] OFS_PRM_A       = 8'h58;
  localparam logic [7:0] OFS_PRM_B       = 8'h5C;
  localparam logic [7:0] OFS_WD_CYC      = 8'h60;
  // Aux select bit positions.
  localparam int AUX_SEL_PRM = 0;
  localparam int AUX_SEL_SSA = 2;
  // Address-change telegram byte positions.
  localparam int SSA_BYTE_ADDR = 0;
  localparam int SSA_BYTE_LOCK = 3;
  localparam int SSA_MAX_LEN   = 244;
  // Parameter telegram byte positions and option bits.
  localparam int PRM_BYTE_STATUS = 0;
  localparam int PRM_BYTE_WD1    = 1;
  localparam int PRM_BYTE_WD2    = 2;
  localparam int PRM_BYTE_TSDR   = 3;
  localparam int PRM_BYTE_IDH    = 4;
  localparam int PRM_BYTE_IDL    = 5;
  localparam int PRM_BYTE_GROUP  = 6;
  localparam int PRM_BYTE_OPT    = 7;
  localparam int PRM_BYTE_EXT2   = 8;
  localparam int PRM_BYTE_EXT3   = 9;
  localparam int PRM_STD_LEN     = 7;
  localparam int OPT_EXT_EN      = 7;
  localparam int OPT_FAIL_SAFE   = 6;
  localparam int OPT_PUBLISHER   = 5;
  localparam int OPT_WD_1MS      = 2;
  localparam int OPT_NO_STOP     = 1;
  localparam int OPT_NO_START    = 0;
  localparam logic [7:0] OPT_RESET   = 8'h00;
  localparam logic [7:0] LOCK_TRUE   = 8'hFF;
  // Watchdog time bases in microseconds and clock rate.
  localparam int WATCHDOG_TIME_BASE_SLOW_US = 10000;
  localparam int WATCHDOG_TIME_BASE_FAST_US = 1000;
  localparam int CLK_MHZ         = 40;
  localparam logic [31:0] WD_SLOW_CYC = 32'(WATCHDOG_TIME_BASE_SLOW_US * CLK_MHZ);
  localparam logic [31:0] WD_FAST_CYC = 32'(WATCHDOG_TIME_BASE_FAST_US * CLK_MHZ);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DONE = 2'b10
  } fsi_rx_state_type;
endpackage

// file: rtl/fsi_tel_if.sv
// Interface carrying received telegram bytes from the top-level stream routing to the service units.
`timescale 1ns/100ps
interface fsi_tel_if;
  logic       start;
  logic       valid;
  logic [7:0] idx;
  logic [7:0] data;
  logic       good;
  logic       bad;
  modport src (output start, output valid, output idx, output data, output good, output bad);
  modport dst (input start, input valid, input idx, input data, input good, input bad);
endinterface

// file: rtl/fsi_prm_decode.sv
// Parameter telegram decoder holding the checked station parameters.
`timescale 1ns/100ps
module fsi_prm_decode (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Telegram bytes.
  fsi_tel_if.dst           tel,
  // Decoded parameters.
  output logic [7:0]       status_byte,
  output logic [7:0]       wd_fact1,
  output logic [7:0]       wd_fact2,
  output logic [7:0]       min_resp,
  output logic [15:0]      ident,
  output logic [7:0]       group_id,
  output logic [7:0]       options,
  output logic [15:0]      ext_status,
  output logic [7:0]       length,
  output logic             new_prm
);
  import fsi_pkg::*;
  typedef struct packed {
    logic [7:0]  st, w1, w2, tsdr, gid, opt, len, cnt, e2, e3;
    logic [15:0] id;
    logic [7:0]  s_st, s_w1, s_w2, s_tsdr, s_gid, s_opt, s_len, s_e2, s_e3;
    logic [15:0] s_id;
    logic        pulse;
  } fsi_prm_state_type;
  fsi_prm_state_type s_r, s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    if (tel.start) begin
      s_nxt.cnt = 8'h00;
    end
    if (tel.valid) begin
      s_nxt.cnt = 8'(s_r.cnt + 8'h01);
      case (int'(tel.idx))
        PRM_BYTE_STATUS: s_nxt.s_st       = tel.data & 8'hF8;
        PRM_BYTE_WD1:    s_nxt.s_w1       = tel.data;
        PRM_BYTE_WD2:    s_nxt.s_w2       = tel.data;
        PRM_BYTE_TSDR:   s_nxt.s_tsdr     = tel.data;
        PRM_BYTE_IDH:    s_nxt.s_id[15:8] = tel.data;
        PRM_BYTE_IDL:    s_nxt.s_id[7:0]  = tel.data;
        PRM_BYTE_GROUP:  s_nxt.s_gid      = tel.data;
        PRM_BYTE_OPT:    s_nxt.s_opt      = tel.data;
        PRM_BYTE_EXT2:   s_nxt.s_e2       = tel.data;
        PRM_BYTE_EXT3:   s_nxt.s_e3       = tel.data;
        default:         s_nxt.s_len      = s_r.s_len;
      endcase
    end
    // A telegram of at least seven bytes is taken; the option byte only if present.
    if (tel.good && int'(s_r.cnt) >= PRM_STD_LEN) begin
      s_nxt.st   = s_r.s_st;
      s_nxt.w1   = s_r.s_w1;
      s_nxt.w2   = s_r.s_w2;
      s_nxt.tsdr = s_r.s_tsdr;
      s_nxt.id   = s_r.s_id;
      s_nxt.gid  = s_r.s_gid;
      s_nxt.len  = s_r.cnt;
      s_nxt.opt  = (int'(s_r.cnt) > PRM_STD_LEN) ? s_r.s_opt : OPT_RESET;
      s_nxt.e2   = s_r.s_e2;
      s_nxt.e3   = s_r.s_e3;
      s_nxt.pulse = int'(s_r.cnt) > PRM_STD_LEN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status_byte = s_r.st;
  assign wd_fact1    = s_r.w1;
  assign wd_fact2    = s_r.w2;
  assign min_resp    = s_r.tsdr;
  assign ident       = s_r.id;
  assign group_id    = s_r.gid;
  assign options     = s_r.opt;
  assign ext_status  = s_r.opt[OPT_EXT_EN] ? {s_r.e2, s_r.e3} : 16'h0000;
  assign length      = s_r.len;
  assign new_prm     = s_r.pulse;
endmodule

// file: rtl/fsi_ssa_unit.sv
// Address-change service unit with station address latch and release handshake.
`timescale 1ns/100ps
module fsi_ssa_unit (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Telegram bytes.
  fsi_tel_if.dst           tel,
  // Control from registers.
  input  wire logic        enabled,
  input  wire logic        release_cmd,
  input  wire logic        host_addr_we,
  input  wire logic [7:0]  host_addr,
  input  wire logic        host_lock_we,
  input  wire logic [7:0]  host_lock,
  // State.
  output logic [7:0]       station,
  output logic [7:0]       lock,
  output logic [7:0]       length,
  output logic             busy,
  output logic             new_ssa,
  output logic             refused
);
  import fsi_pkg::*;
  typedef struct packed {
    fsi_rx_state_type st;
    logic [7:0] addr, lck, len, cnt, n_addr, n_lck;
    logic       pulse, ref_p;
  } fsi_ssa_state_type;
  fsi_ssa_state_type s_r, s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    s_nxt.ref_p = 1'b0;
    if (host_addr_we) s_nxt.addr = host_addr;
    if (host_lock_we) s_nxt.lck  = host_lock;
    case (s_r.st)
      ST_IDLE: begin
        if (tel.start && enabled) begin
          s_nxt.st  = ST_FILL;
          s_nxt.cnt = 8'h00;
        end
      end
      ST_FILL: begin
        if (tel.valid && int'(s_r.cnt) < SSA_MAX_LEN) begin
          s_nxt.cnt = 8'(s_r.cnt + 8'h01);
          if (int'(tel.idx) == SSA_BYTE_ADDR) s_nxt.n_addr = tel.data;
          if (int'(tel.idx) == SSA_BYTE_LOCK) s_nxt.n_lck  = tel.data;
        end
        if (tel.bad) begin
          s_nxt.st = ST_IDLE;
        end else if (tel.good) begin
          s_nxt.st    = ST_DONE;
          s_nxt.len   = s_r.cnt;
          s_nxt.pulse = 1'b1;
          s_nxt.addr  = s_r.n_addr;
          s_nxt.lck   = s_r.n_lck;
        end
      end
      ST_DONE: begin
        if (tel.start) s_nxt.ref_p = 1'b1;
        if (release_cmd) s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign station = s_r.addr;
  assign lock    = s_r.lck;
  assign length  = s_r.len;
  assign busy    = (s_r.st == ST_DONE);
  assign new_ssa = s_r.pulse;
  assign refused = s_r.ref_p;
endmodule

// file: rtl/fsi_top.sv
// Top of the fieldbus slave address-change and parameter intake block with APB registers.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module fsi_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Received telegram stream from the bus receiver.
  input  wire logic        rx_ssa,
  input  wire logic        rx_start,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_good,
  input  wire logic        rx_bad,
  // Service events and decoded controls.
  output logic             new_address_data_irq,
  output logic             new_prm_irq,
  output logic             ssa_aux_sel,
  output logic             prm_aux_sel,
  output logic             extensions_enable,
  output logic             fail_safe,
  output logic             publisher_enable,
  output logic             no_stop_check,
  output logic             no_start_check,
  output logic [31:0]      watchdog_cycles
);
  import fsi_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [7:0]  ptr;
    logic [2:0]  aux;
    logic        sel_ssa;
    logic [7:0]  idx;
    logic        irq_ssa, irq_prm;
    logic        ext, fs, pub, nstop, nstart;
    logic [31:0] wd;
  } fsi_top_state_type;
  fsi_top_state_type s_r, s_nxt;

  fsi_tel_if ssa_tel ();
  fsi_tel_if prm_tel ();

  logic [7:0]  ssa_station, ssa_lock, ssa_len, prm_len, p_st, p_w1, p_w2, p_tsdr, p_gid, p_opt;
  logic [15:0] p_id, p_ext;
  logic        ssa_busy, ssa_new, ssa_refused, prm_new;
  logic        acc, wr, rd;
  logic [31:0] watchdog_time_base;

  assign acc = psel && penable && s_r.ready;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  // Route the stream to one service, chosen at telegram start.
  assign ssa_tel.start = rx_start && rx_ssa;
  assign ssa_tel.valid = rx_valid && s_r.sel_ssa;
  assign ssa_tel.idx   = s_r.idx;
  assign ssa_tel.data  = rx_data;
  assign ssa_tel.good  = rx_good && s_r.sel_ssa;
  assign ssa_tel.bad   = rx_bad && s_r.sel_ssa;
  assign prm_tel.start = rx_start && !rx_ssa;
  assign prm_tel.valid = rx_valid && !s_r.sel_ssa;
  assign prm_tel.idx   = s_r.idx;
  assign prm_tel.data  = rx_data;
  assign prm_tel.good  = rx_good && !s_r.sel_ssa;
  assign prm_tel.bad   = rx_bad && !s_r.sel_ssa;

  fsi_ssa_unit u_ssa (
    .pclk         (pclk),
    .presetn      (presetn),
    .tel          (ssa_tel.dst),
    .enabled      (s_r.ptr != 8'h00),
    .release_cmd  (rd && paddr == OFS_BUF_RELEASE),
    .host_addr_we (wr && paddr == OFS_STATION),
    .host_addr    (pwdata[7:0]),
    .host_lock_we (wr && paddr == OFS_LOCK),
    .host_lock    (pwdata[7:0]),
    .station      (ssa_station),
    .lock         (ssa_lock),
    .length       (ssa_len),
    .busy         (ssa_busy),
    .new_ssa      (ssa_new),
    .refused      (ssa_refused)
  );

  fsi_prm_decode u_prm (
    .pclk        (pclk),
    .presetn     (presetn),
    .tel         (prm_tel.dst),
    .status_byte (p_st),
    .wd_fact1    (p_w1),
    .wd_fact2    (p_w2),
    .min_resp    (p_tsdr),
    .ident       (p_id),
    .group_id    (p_gid),
    .options     (p_opt),
    .ext_status  (p_ext),
    .length      (prm_len),
    .new_prm     (prm_new)
  );

  assign watchdog_time_base = p_opt[OPT_WD_1MS] ? WD_FAST_CYC : WD_SLOW_CYC;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.ready = psel && !penable;
    s_nxt.err   = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    if (rx_start) begin
      s_nxt.sel_ssa = rx_ssa;
      s_nxt.idx     = 8'h00;
    end else if (rx_valid) begin
      s_nxt.idx = 8'(s_r.idx + 8'h01);
    end
    if (psel && !penable) begin
      case (paddr)
        OFS_BUF_RELEASE: s_nxt.rdata = 32'h0000_0000;
        OFS_AUX_SEL:     s_nxt.rdata = {29'h0, s_r.aux};
        OFS_SSA_PTR:     s_nxt.rdata = {24'h0, s_r.ptr};
        OFS_STATION:     s_nxt.rdata = {24'h0, ssa_station};
        OFS_LOCK:        s_nxt.rdata = {24'h0, ssa_lock};
        OFS_SSA_LEN:     s_nxt.rdata = {24'h0, ssa_len};
        OFS_STATUS:      s_nxt.rdata = {30'h0, ssa_refused, ssa_busy};
        OFS_PRM_LEN:     s_nxt.rdata = {24'h0, prm_len};
        OFS_PRM_A:       s_nxt.rdata = {p_st, p_w1, p_w2, p_tsdr};
        OFS_PRM_B:       s_nxt.rdata = {p_id, p_gid, p_opt};
        OFS_WD_CYC:      s_nxt.rdata = s_r.wd;
        default:         s_nxt.err   = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        OFS_AUX_SEL: s_nxt.aux = pwdata[2:0];
        OFS_SSA_PTR: s_nxt.ptr = pwdata[7:0];
        default:     s_nxt.aux = s_r.aux;
      endcase
    end
    s_nxt.irq_ssa = ssa_new;
    s_nxt.irq_prm = prm_new;
    s_nxt.ext     = p_opt[OPT_EXT_EN];
    s_nxt.fs      = p_opt[OPT_FAIL_SAFE];
    s_nxt.pub     = p_opt[OPT_PUBLISHER];
    s_nxt.nstop   = p_opt[OPT_NO_STOP];
    s_nxt.nstart  = p_opt[OPT_NO_START];
    s_nxt.wd      = 32'(watchdog_time_base * 32'(p_w1) * 32'(p_w2));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata               = s_r.rdata;
  assign pready               = s_r.ready;
  // The error flag is only ever set together with ready, so it drives the pin directly.
  assign pslverr              = s_r.err;
  assign new_address_data_irq = s_r.irq_ssa;
  assign new_prm_irq          = s_r.irq_prm;
  assign ssa_aux_sel          = s_r.aux[AUX_SEL_SSA];
  assign prm_aux_sel          = s_r.aux[AUX_SEL_PRM];
  assign extensions_enable    = s_r.ext;
  assign fail_safe            = s_r.fs;
  assign publisher_enable     = s_r.pub;
  assign no_stop_check        = s_r.nstop;
  assign no_start_check       = s_r.nstart;
  assign watchdog_cycles      = s_r.wd;
endmodule

// file: bench/fsi_props.sv
// Checker for the APB answer, service events and decoded option controls.
`timescale 1ns/100ps
module fsi_props import fsi_pkg::*; (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Watched ports.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_good,
  input wire logic        new_address_data_irq,
  input wire logic        new_prm_irq,
  input wire logic        ssa_aux_sel,
  input wire logic        extensions_enable,
  input wire logic        fail_safe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       held_r;
  logic [2:0] since_r;
  logic       rel_rd;
  logic       aux_wr;
  logic       mapped;
  assign rel_rd = psel && penable && pready && !pwrite && paddr == OFS_BUF_RELEASE;
  assign aux_wr = psel && penable && pwrite && paddr == OFS_AUX_SEL;
  assign mapped = paddr == OFS_BUF_RELEASE || paddr == OFS_AUX_SEL
                  || (paddr >= OFS_SSA_PTR && paddr <= OFS_WD_CYC && paddr[1:0] == 2'b00);
  // Tracks a delivered address change until the host frees the buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r  <= 1'b0;
      since_r <= 3'h7;
    end else begin
      held_r  <= new_address_data_irq | (held_r & ~rel_rd);
      since_r <= rx_good ? 3'h0 : since_r + {2'h0, since_r != 3'h7};
    end
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready && penable ##1 !pready;
  endsequence
  pready_answer_a: assert property (apb_setup |=> apb_answer)
    else $error("setup cycle not answered in the next cycle");
  release_zero_a: assert property (rel_rd |-> prdata == 32'h0)
    else $error("release location read nonzero");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address map");
  ssa_irq_a: assert property (new_address_data_irq |-> $past(rx_good, 2) ##1 !new_address_data_irq)
    else $error("address event not two cycles after good end");
  prm_irq_a: assert property (new_prm_irq |-> $past(rx_good, 2) ##1 !new_prm_irq)
    else $error("parameter event not two cycles after good end");
  ssa_rearm_a: assert property (new_address_data_irq |-> !held_r)
    else $error("address change accepted before buffer release");
  options_cause_a: assert property ($changed(extensions_enable) || $changed(fail_safe) |-> since_r <= 3'h4)
    else $error("option output changed without a telegram");
  aux_cause_a: assert property ($changed(ssa_aux_sel) |-> $past(aux_wr) || $past(aux_wr, 2))
    else $error("aux select changed without a register write");
endmodule
bind fsi_top fsi_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_good(rx_good),
  .new_address_data_irq(new_address_data_irq), .new_prm_irq(new_prm_irq),
  .ssa_aux_sel(ssa_aux_sel), .extensions_enable(extensions_enable), .fail_safe(fail_safe)
);

// file: bench/fsi_master_model.sv
// Behavioural fieldbus master that streams telegram bytes into the intake block.
`timescale 1ns/100ps
module fsi_master_model (
  // Clock.
  input wire logic   pclk,
  // Telegram stream.
  output logic       rx_ssa,
  output logic       rx_start,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_good,
  output logic       rx_bad
);
  initial begin
    rx_ssa   = 1'b0;
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_good  = 1'b0;
    rx_bad   = 1'b0;
  end
  // Between bytes the data lines show the inverse of the last byte; after a gapped last byte they show that byte again.
  task automatic send(input logic ssa, input logic [7:0] b [16], input int len, input logic bad,
                      input int gap);
    @(posedge pclk);
    rx_ssa   <= ssa;
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= b[i];
      @(posedge pclk);
      if (gap > 0) begin
        rx_valid <= 1'b0;
        rx_data  <= ~b[i];
        repeat (gap) @(posedge pclk);
      end
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    @(posedge pclk);
    rx_good <= !bad;
    rx_bad  <= bad;
    @(posedge pclk);
    rx_good <= 1'b0;
    rx_bad  <= 1'b0;
  endtask
endmodule

// file: bench/fsi_top_bench.sv
// Self-checking bench for the address-change and parameter intake block.
`timescale 1ns/100ps
module fsi_top_bench;
  import fsi_pkg::*;
  localparam logic [7:0] OPTS [8] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02, 8'h01, 8'h00, 8'hE7};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_ssa;
  logic        rx_start;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_good;
  logic        rx_bad;
  logic        ssa_irq;
  logic        prm_irq;
  logic        ssa_aux_sel;
  logic        prm_aux_sel;
  logic [4:0]  opt_out;
  logic [31:0] wd_cyc;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  tb [16];
  logic [7:0]  opt;
  logic [7:0]  stn;
  logic [7:0]  lk;
  int          fails;
  int          samples_checked;
  int          seed;
  int          n_ssa = 0;
  int          n_prm = 0;
  int          e_ssa;
  int          e_prm;
  int          len;

  fsi_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_ssa(rx_ssa), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_good(rx_good), .rx_bad(rx_bad), .new_address_data_irq(ssa_irq),
    .new_prm_irq(prm_irq), .ssa_aux_sel(ssa_aux_sel), .prm_aux_sel(prm_aux_sel),
    .extensions_enable(opt_out[4]), .fail_safe(opt_out[3]), .publisher_enable(opt_out[2]),
    .no_stop_check(opt_out[1]), .no_start_check(opt_out[0]), .watchdog_cycles(wd_cyc)
  );
  fsi_master_model master (
    .pclk(pclk), .rx_ssa(rx_ssa), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_good(rx_good), .rx_bad(rx_bad)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_ssa <= n_ssa + int'(ssa_irq === 1'b1);
    n_prm <= n_prm + int'(prm_irq === 1'b1);
  end

  function automatic logic [31:0] wd_exp(input logic [7:0] o, input logic [7:0] a,
                                         input logic [7:0] b);
    return (o[OPT_WD_1MS] ? WD_FAST_CYC : WD_SLOW_CYC) * a * b;
  endfunction
  task automatic end_sim;
    $display("Counts: %0d checked, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "bus answer");
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  task automatic fill;
    for (int i = 0; i < 16; i++) begin
      tb[i] = 8'($random(seed));
    end
  endtask
  task automatic send(input logic ssa, input int n, input logic bad);
    master.send(ssa, tb, n, bad, {$random(seed)} % 3);
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    #1000000;
    fails++;
    $display("[FAIL] %0t run did not finish in time", $time);
    end_sim;
  end

  initial begin
    seed = 32'h7549CC9C;
    {fails, samples_checked, e_ssa, e_prm} = '0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk(wd_cyc, 32'h0, "watchdog at reset");
    chk({27'h0, opt_out}, 32'h0, "options at reset");
    rchk(OFS_BUF_RELEASE, 32'h0, "release reads zero");
    apb(1'b1, 8'h7C, 32'h1);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 8'h7C, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped read");
    $display("test reset done");
    apb(1'b1, OFS_AUX_SEL, 32'h5);
    repeat (2) @(posedge pclk);
    chk({30'h0, ssa_aux_sel, prm_aux_sel}, 32'h3, "aux select outputs");
    rchk(OFS_AUX_SEL, 32'h5, "aux select readback");
    apb(1'b1, OFS_SSA_PTR, 32'h0);
    apb(1'b1, OFS_STATION, 32'h23);
    apb(1'b1, OFS_LOCK, {24'h0, LOCK_TRUE});
    fill;
    send(1'b1, 6, 1'b0);
    chk(n_ssa, 0, "disabled service events");
    rchk(OFS_STATION, 32'h23, "disabled keeps address");
    $display("test registers done");
    stn = 8'h23;
    lk  = LOCK_TRUE;
    apb(1'b1, OFS_SSA_PTR, 32'h10);
    for (int k = 0; k < 4; k++) begin
      fill;
      len = 4 + {$random(seed)} % 12;
      send(1'b1, len, k == 2);
      if (k == 0 || k == 3) begin
        e_ssa++;
        stn = tb[SSA_BYTE_ADDR];
        lk  = tb[SSA_BYTE_LOCK];
        rchk(OFS_SSA_LEN, len, "address-change length");
      end
      chk(n_ssa, e_ssa, "address-change events");
      rchk(OFS_STATION, {24'h0, stn}, "station address");
      rchk(OFS_LOCK, {24'h0, lk}, "lock byte");
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h1, {31'h0, k != 2}, "buffer held");
      if (k == 1) begin
        rchk(OFS_BUF_RELEASE, 32'h0, "release read");
      end
    end
    rchk(OFS_BUF_RELEASE, 32'h0, "final release");
    $display("test address change done");
    for (int k = 0; k < 9; k++) begin
      fill;
      opt = (k == 7) ? (tb[PRM_BYTE_OPT] & 8'hE7) : OPTS[k % 8];
      tb[PRM_BYTE_OPT] = opt;
      tb[PRM_BYTE_WD1] = 8'(1 + {$random(seed)} % 60);
      tb[PRM_BYTE_WD2] = 8'(2 + {$random(seed)} % 59);
      len = (k == 6) ? 7 : 8 + 4 * (k % 2);
      if (len == 7) begin
        opt = OPT_RESET;
      end
      e_prm = e_prm + int'(len > 7);
      send(1'b0, len, k == 8);
      if (k == 8) begin
        e_prm--;
        opt = OPTS[7 % 8] & 8'h00;
        len = 8;
      end
      if (k != 8) begin
        chk(n_prm, e_prm, "parameter events");
        chk({27'h0, opt_out}, {27'h0, opt[7:5], opt[1:0]}, "option outputs");
        chk(wd_cyc, wd_exp(opt, tb[1], tb[2]), "watchdog cycles");
        rchk(OFS_PRM_A, {tb[0] & 8'hF8, tb[1], tb[2], tb[3]}, "station parameters");
        rchk(OFS_PRM_B, {tb[4], tb[5], tb[6], opt}, "ident group options");
        if (len > 7) begin
          rchk(OFS_PRM_LEN, len, "parameter length");
        end
      end else begin
        chk(n_prm, e_prm, "faulty telegram ignored");
      end
    end
    $display("test parameters done");
    end_sim;
  end
endmodule
